// >>> verilog/sws_device.sv
// Device end: presence answer, write slot sampling, read slot answers.
// Assumes line level is synchronous to clock; user supplies data bits.
`timescale 1ns/1ns
module sws_device (
  input  wire logic             clock,
  input  wire logic             reset_n,
  sws_line_if.device            line,
  input  wire logic             txBit,
  input  wire logic             opDone,
  input  wire logic             lineFed,
  output sws_pkg::sws_byte_t    rxByte,
  output logic                  rxValid,
  output logic                  rxFunction,
  output logic                  txTaken,
  output logic                  resetSeen,
  output logic                  presenceDone,
  output logic                  online
);
  import sws_pkg::*;

  typedef enum logic [1:0] {D_IDLE, D_SLOT, D_PWAIT, D_PLOW} sws_dstate_t;
  typedef enum logic [1:0] {G_ROM, G_ADDR, G_FUNC, G_DATA} sws_stage_t;
  typedef enum logic [1:0] {MD_WRITE, MD_DATA, MD_SUPPLY, MD_POLL} sws_mode_t;

  typedef struct packed {
    sws_dstate_t state;
    sws_stage_t  stage;
    sws_mode_t   mode;
    sws_us_t     cnt;
    sws_us_t     lowCnt;
    logic        prevDq;
    logic        oeN;
    logic        online;
    logic        readSlot;
    sws_byte_t   shift;
    logic [2:0]  bitCnt;
    logic [3:0]  idLeft;
    sws_byte_t   rxByte;
    logic        rxValid;
    logic        rxFunction;
    logic        txTaken;
    logic        resetSeen;
    logic        presenceDone;
  } sws_dreg_t;

  localparam sws_dreg_t RESET_VAL = '{state: D_IDLE, stage: G_ROM, mode: MD_WRITE,
                                      prevDq: 1'b1, oeN: 1'b1, default: '0};

  sws_dreg_t r;
  sws_dreg_t next_r;
  logic      tick;
  logic      restart;
  sws_byte_t b;

  sws_us_tick u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .restart (restart),
    .tick    (tick)
  );

  // Level to leave on the line in a read slot: 1 releases, 0 pulls low.
  function automatic logic answer(sws_mode_t m, logic d, logic done, logic fed);
    unique case (m)
      MD_SUPPLY: answer = !fed;                        // [R22]
      MD_POLL:   answer = done;                        // [R20]
      default:   answer = d;
    endcase
  endfunction : answer

  always_comb
  begin
    next_r              = r;
    restart             = 1'b0;
    b                   = {line.dq, r.shift[7:1]};
    next_r.prevDq       = line.dq;
    next_r.rxValid      = 1'b0;
    next_r.txTaken      = 1'b0;
    next_r.resetSeen    = 1'b0;
    next_r.presenceDone = 1'b0;
    if (line.dq)
      next_r.lowCnt = '0;
    else if (tick && r.lowCnt < RST_DET_US)
      next_r.lowCnt = r.lowCnt + sws_us_t'(1);
    if (tick)
      next_r.cnt = r.cnt + sws_us_t'(1);

    if (!r.prevDq && line.dq && r.lowCnt >= RST_DET_US && r.state != D_PLOW)
    begin
      // A long low in any state but D_PLOW drops the transfer and starts a presence answer.
      next_r.state     = D_PWAIT;                      // [R23] [R2]
      next_r.cnt       = '0;
      next_r.oeN       = 1'b1;
      next_r.stage     = G_ROM;
      next_r.mode      = MD_WRITE;
      next_r.bitCnt    = '0;
      next_r.online    = 1'b0;                         // [R3]
      next_r.resetSeen = 1'b1;
      restart          = 1'b1;
    end
    else
    begin
      unique case (r.state)
        D_IDLE:
          if (r.prevDq && !line.dq && r.online)        // [R4]
          begin
            next_r.state    = D_SLOT;
            next_r.cnt      = '0;
            restart         = 1'b1;
            next_r.readSlot = (r.mode != MD_WRITE);    // [R10]
            if (r.mode != MD_WRITE)
            begin
              next_r.oeN     = answer(r.mode, txBit, opDone, lineFed); // [R14] [R24]
              next_r.txTaken = (r.mode == MD_DATA);
            end
          end
        D_SLOT:
          if (r.readSlot && next_r.cnt == RD_HOLD_US)
          begin
            next_r.oeN   = 1'b1;                       // [R15] [R14]
            next_r.state = D_IDLE;
          end
          else if (!r.readSlot && next_r.cnt == W_SAMPLE_US)
          begin
            next_r.shift  = b;                         // [R9] [R5]
            next_r.bitCnt = r.bitCnt + 3'h1;
            next_r.state  = D_IDLE;
            if (r.bitCnt == LAST_BIT)
            begin
              next_r.rxByte     = b;
              next_r.rxValid    = 1'b1;
              next_r.rxFunction = (r.stage == G_FUNC);
              unique case (r.stage)
                G_ROM:
                begin
                  next_r.stage  = (b == CMD_MATCH) ? G_ADDR : G_FUNC;
                  next_r.idLeft = ID_BYTES;
                end
                G_ADDR:
                begin
                  next_r.idLeft = r.idLeft - 4'h1;
                  if (r.idLeft == 4'h1)
                    next_r.stage = G_FUNC;
                end
                G_FUNC:
                begin
                  next_r.stage = G_DATA;
                  if (b == CMD_READ_PAD)
                    next_r.mode = MD_DATA;
                  else if (b == CMD_SUPPLY)
                    next_r.mode = MD_SUPPLY;
                  else if (b == CMD_CONVERT || b == CMD_RECALL)
                    next_r.mode = MD_POLL;             // [R11]
                end
                G_DATA: next_r.stage = G_DATA;
              endcase
            end
          end
        D_PWAIT:
          if (next_r.cnt == PRES_DELAY_US)
          begin
            next_r.oeN   = 1'b0;                       // [R2]
            next_r.state = D_PLOW;
            next_r.cnt   = '0;
          end
        D_PLOW:
          if (next_r.cnt == PRES_LOW_US)
          begin
            next_r.oeN          = 1'b1;
            next_r.state        = D_IDLE;
            next_r.online       = 1'b1;                // [R3]
            next_r.presenceDone = 1'b1;
          end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      r <= RESET_VAL;
    else
      r <= next_r;
  end

  assign line.deviceOut  = 1'b0;
  assign line.deviceOeN  = r.oeN;
  assign rxByte          = r.rxByte;
  assign rxValid         = r.rxValid;
  assign rxFunction      = r.rxFunction;
  assign txTaken         = r.txTaken;
  assign resetSeen       = r.resetSeen;
  assign presenceDone    = r.presenceDone;
  assign online          = r.online;
endmodule : sws_device

// >>> verilog/sws_pkg.sv
// Shared constants and types for the single wire slot link.
// Assumes one 20 MHz clock; all slot timing runs from a microsecond tick.
package sws_pkg;
  localparam int CLK_HZ     = 20_000_000;
  localparam int US_HZ      = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / US_HZ;
  localparam int CNT_W      = 10;

  typedef logic [CNT_W-1:0] sws_us_t;
  typedef logic [7:0]       sws_byte_t;

  // Master timing, microseconds.
  localparam sws_us_t RST_LOW_US     = sws_us_t'(480);
  localparam sws_us_t RST_WAIT_US    = sws_us_t'(480);
  localparam sws_us_t PRES_SAMPLE_US = sws_us_t'(70);
  localparam sws_us_t SLOT_US        = sws_us_t'(60);
  localparam sws_us_t REC_US         = sws_us_t'(5);
  localparam sws_us_t W1_LOW_US      = sws_us_t'(6);
  localparam sws_us_t RD_LOW_US      = sws_us_t'(2);
  localparam sws_us_t RD_SAMPLE_US   = sws_us_t'(12);

  // Device timing, microseconds.
  localparam sws_us_t RST_DET_US     = sws_us_t'(400);
  localparam sws_us_t PRES_DELAY_US  = sws_us_t'(30);
  localparam sws_us_t PRES_LOW_US    = sws_us_t'(120);
  localparam sws_us_t W_SAMPLE_US    = sws_us_t'(30);
  localparam sws_us_t RD_HOLD_US     = sws_us_t'(30);

  localparam sws_byte_t CMD_MATCH    = 8'h55;
  localparam sws_byte_t CMD_CONVERT  = 8'h44;
  localparam sws_byte_t CMD_RECALL   = 8'hb8;
  localparam sws_byte_t CMD_READ_PAD = 8'hbe;
  localparam sws_byte_t CMD_SUPPLY   = 8'hb4;
  localparam sws_byte_t CRC_POLY     = 8'h8c;
  localparam logic [3:0] ID_BYTES    = 4'h8;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  typedef enum logic [2:0] {
    OP_RESET,
    OP_WRITE_BIT,
    OP_READ_BIT,
    OP_WRITE_BYTE,
    OP_READ_BYTE
  } sws_op_t;
endpackage : sws_pkg

// >>> verilog/sws_line_if.sv
// Open-drain data line shared by the master end and the device end.
// The line idles high through the pullup; any enabled driver pulls it low.
`timescale 1ns/1ns
interface sws_line_if;
  logic masterOut;
  logic masterOeN;
  logic strongPullup;
  logic deviceOut;
  logic deviceOeN;
  logic dq;

  assign dq = !((!masterOeN && !masterOut) || (!deviceOeN && !deviceOut));

  modport master (input dq, output masterOut, output masterOeN, output strongPullup);
  modport device (input dq, output deviceOut, output deviceOeN);
endinterface : sws_line_if

// >>> verilog/sws_us_tick.sv
// Microsecond enable divider with restart, so slot timing starts on an edge.
// Assumes the clock rate given in the package.
`timescale 1ns/1ns
module sws_us_tick #(
  parameter int CYCLES = sws_pkg::CYC_PER_US
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      tick
);
  import sws_pkg::*;

  localparam int W = $clog2(CYCLES);

  generate
    if (CYCLES < 2)
    begin : g_check
      $error("sws_us_tick needs at least two cycles per tick.");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } sws_tick_t;

  sws_tick_t r;
  sws_tick_t next_r;

  always_comb
  begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (restart)
      next_r.cnt = '0;
    else if (r.cnt == W'(CYCLES - 1))
    begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end
    else
      next_r.cnt = r.cnt + W'(1);
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign tick = r.tick;
endmodule : sws_us_tick

// >>> verilog/sws_master.sv
// Master end: reset, write and read slots, byte transfers and CRC check.
// Assumes line level is synchronous to clock; one operation at a time.
//
// Functional notes
// R1 - Reset pulse holds line low 480 us.
// R2 - Device answers presence after 15-60 us delay.
// R3 - No exchange before reset and presence.
// R4 - Master starts every slot; device only presence.
// R5 - One data bit per slot.
// R6 - Write slot 60 us, recovery 1 us.
// R7 - Write one releases within 15 us.
// R8 - Write zero holds low whole slot.
// R9 - Device samples write slot 15-60 us.
// R10 - Device sends only in read slots.
// R11 - Polling reads allowed after convert, recall.
// R12 - Read slot 60 us, recovery 1 us.
// R13 - Read slot opens with 1 us low.
// R14 - Device pulls low for zero, then releases.
// R15 - Read bit valid 15 us; sample inside.
// R16 - Keep low short, sample late before 15 us.
// R17 - Select command and identity sent LSB first.
// R18 - Strong pullup held during conversion.
// R19 - Recheck CRC over nine bytes, reread on mismatch; the master only flags crcOk and never rereads.
// R20 - Busy operation reads zero, done reads one.
// R21 - Strong pullup within 10 us of command.
// R22 - Supply query: line-powered device pulls low.
// R23 - Device restarts on reset-length low anywhere; the device ignores one that ends while it is in D_PLOW.
// R24 - Drivers only pull low, else release.
`timescale 1ns/1ns
module sws_master (
  input  wire logic             clock,
  input  wire logic             reset_n,
  sws_line_if.master            line,
  input  wire logic             cmdValid,
  input  sws_pkg::sws_op_t      cmdOp,
  input  sws_pkg::sws_byte_t    cmdData,
  input  wire logic             spuEn,
  input  wire logic             crcClear,
  output logic                  cmdReady,
  output logic                  done,
  output logic                  rxBit,
  output sws_pkg::sws_byte_t    rxByte,
  output logic                  crcOk
);
  import sws_pkg::*;

  typedef enum logic {M_IDLE, M_SLOT} sws_mstate_t;

  typedef struct packed {
    sws_mstate_t state;
    sws_op_t     op;
    sws_us_t     cnt;
    logic        oeN;
    logic        ready;
    logic        done;
    logic        rxBit;
    sws_byte_t   shift;
    logic [2:0]  bitsLeft;
    sws_byte_t   rxByte;
    sws_byte_t   crc;
    logic        crcOk;
    logic        spu;
  } sws_mreg_t;

  localparam sws_mreg_t RESET_VAL = '{state: M_IDLE, op: OP_RESET, oeN: 1'b1,
                                      crcOk: 1'b1, default: '0};

  sws_mreg_t r;
  sws_mreg_t next_r;
  logic      tick;
  logic      restart;

  sws_us_tick u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .restart (restart),
    .tick    (tick)
  );

  function automatic logic isRead(sws_op_t op);
    isRead = (op == OP_READ_BIT) || (op == OP_READ_BYTE);
  endfunction : isRead

  function automatic logic isByte(sws_op_t op);
    isByte = (op == OP_WRITE_BYTE) || (op == OP_READ_BYTE);
  endfunction : isByte

  // Time from the opening fall until the master lets go of the line.
  function automatic sws_us_t lowTime(sws_op_t op, logic b);
    if (op == OP_RESET)
      lowTime = RST_LOW_US;                            // [R1]
    else if (isRead(op))
      lowTime = RD_LOW_US;                             // [R13] [R16]
    else if (b)
      lowTime = W1_LOW_US;                             // [R7]
    else
      lowTime = SLOT_US;                               // [R8]
  endfunction : lowTime

  function automatic sws_us_t sampleTime(sws_op_t op);
    if (op == OP_RESET)
      sampleTime = RST_LOW_US + PRES_SAMPLE_US;        // [R2]
    else
      sampleTime = RD_SAMPLE_US;                       // [R15] [R16]
  endfunction : sampleTime

  // Slot length including the released recovery gap before the next fall.
  function automatic sws_us_t endTime(sws_op_t op);
    if (op == OP_RESET)
      endTime = RST_LOW_US + RST_WAIT_US;
    else
      endTime = SLOT_US + REC_US;                      // [R6] [R12]
  endfunction : endTime

  // Reflected CRC-8 step; a good nine-byte block leaves the register at zero.
  function automatic sws_byte_t crcStep(sws_byte_t c, logic d);
    logic fb;
    fb      = c[0] ^ d;
    crcStep = {1'b0, c[7:1]} ^ (fb ? CRC_POLY : 8'h00);
  endfunction : crcStep

  always_comb
  begin
    next_r      = r;
    restart     = 1'b0;
    next_r.done = 1'b0;
    // Strong pullup only while no slot runs, so it never masks a slot.
    next_r.spu  = (r.state == M_IDLE) && spuEn;        // [R18] [R21]
    if (crcClear)
      next_r.crc = '0;
    unique case (r.state)
      M_IDLE:
      begin
        next_r.ready = 1'b1;
        if (cmdValid && r.ready)
        begin
          next_r.op       = cmdOp;
          next_r.shift    = cmdData;                   // [R17]
          next_r.bitsLeft = isByte(cmdOp) ? LAST_BIT : 3'h0;
          next_r.cnt      = '0;
          next_r.oeN      = 1'b0;                      // [R4] [R24]
          next_r.ready    = 1'b0;
          next_r.spu      = 1'b0;
          next_r.state    = M_SLOT;
          restart         = 1'b1;
        end
      end
      M_SLOT:
        if (tick)
        begin
          next_r.cnt = r.cnt + sws_us_t'(1);
          next_r.oeN = !(next_r.cnt < lowTime(r.op, r.shift[0]));
          if (next_r.cnt == sampleTime(r.op))
          begin
            if (r.op == OP_RESET)
              next_r.rxBit = !line.dq;                 // [R3]
            else if (isRead(r.op))
            begin
              next_r.rxBit = line.dq;                  // [R5] [R15]
              next_r.shift = {line.dq, r.shift[7:1]};
              if (r.op == OP_READ_BYTE)
                next_r.crc = crcStep(next_r.crc, line.dq); // [R19]
            end
          end
          if (next_r.cnt == endTime(r.op))
          begin
            if (!isRead(r.op))
              next_r.shift = {1'b0, r.shift[7:1]};     // [R17]
            if (r.bitsLeft != 3'h0)
            begin
              next_r.bitsLeft = r.bitsLeft - 3'h1;
              next_r.cnt      = '0;
              next_r.oeN      = 1'b0;
              restart         = 1'b1;
            end
            else
            begin
              next_r.state = M_IDLE;
              next_r.done  = 1'b1;
              if (r.op == OP_READ_BYTE)
                next_r.rxByte = next_r.shift;
            end
          end
        end
    endcase
    next_r.crcOk = (next_r.crc == 8'h00);              // [R19]
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      r <= RESET_VAL;
    else
      r <= next_r;
  end

  assign line.masterOut    = 1'b0;
  assign line.masterOeN    = r.oeN;
  assign line.strongPullup = r.spu;
  assign cmdReady          = r.ready;
  assign done              = r.done;
  assign rxBit             = r.rxBit;
  assign rxByte            = r.rxByte;
  assign crcOk             = r.crcOk;
endmodule : sws_master

// >>> tb/sws_monitor.sv
// Checker for the shared line: slot, reset and presence timing of both ends.
// Assumes the 20 MHz link clock, so one microsecond is 20 cycles.
`timescale 1ns/1ns
module sws_monitor (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic masterOut,
  input wire logic masterOeN,
  input wire logic strongPullup,
  input wire logic deviceOut,
  input wire logic deviceOeN,
  input wire logic dq
);
  localparam int RST_CYC = 9599;
  typedef struct packed {
    logic        mPrev;
    logic        rstRel;
    logic [15:0] mLow;
    logic [15:0] mHigh;
    logic [15:0] sinceFall;
    logic [15:0] dLow;
    logic        presSeen;
  } sws_mon_t;
  sws_mon_t st;
  sws_mon_t next_st;

  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : inc

  // The counters saturate, so a long idle spell never wraps into a short one.
  always_comb
  begin
    next_st = st;
    next_st.mPrev = masterOeN;
    next_st.mLow = masterOeN ? 16'h0000 : inc(st.mLow);
    next_st.mHigh = masterOeN ? inc(st.mHigh) : 16'h0000;
    next_st.dLow = deviceOeN ? 16'h0000 : inc(st.dLow);
    next_st.sinceFall = (st.mPrev && !masterOeN) ? 16'h0000 : inc(st.sinceFall);
    // A device pull since the last reset release; the presence deadline is checked on this flag.
    next_st.presSeen = st.presSeen || !deviceOeN;
    if (!st.mPrev && masterOeN && st.mLow >= RST_CYC)
    begin
      next_st.rstRel   = 1'b1;
      next_st.presSeen = 1'b0;
    end
    else if (st.mPrev && !masterOeN)
      next_st.rstRel = 1'b0;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= '{1'b1, 1'b0, 16'h0000, 16'hffff, 16'hffff, 16'h0000, 1'b0};
    else
      st <= next_st;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_MASTER_LOW: assert property ($rose(masterOeN) |->
    st.mLow <= 300 || (st.mLow >= 1199 && st.mLow <= 1300) || st.mLow >= RST_CYC) else $error("bad master low time");
  AST_READ_OPEN: assert property ($rose(masterOeN) |-> st.mLow >= 20)
    else $error("master low under 1 us");
  AST_RECOVERY: assert property ($fell(masterOeN) |-> st.mHigh >= 20)
    else $error("recovery under 1 us");
  AST_SLOT_LEN: assert property ($fell(masterOeN) |-> st.sinceFall >= 1219)
    else $error("slot too short");
  AST_DEV_START: assert property ($fell(deviceOeN) |->
    st.sinceFall <= 6 || (st.rstRel && st.mHigh >= 300 && st.mHigh <= 1200)) else $error("device drove unasked");
  AST_PRES_DUE: assert property (st.rstRel && st.mHigh == 16'h04b0 |-> st.presSeen)
    else $error("no presence answer");
  AST_PRES_LEN: assert property ($rose(deviceOeN) && st.rstRel |-> st.dLow >= 1199 && st.dLow <= 4800)
    else $error("bad presence length");
  AST_DEV_REL: assert property ($rose(deviceOeN) && !st.rstRel |-> st.dLow < 1200 && st.sinceFall >= 300)
    else $error("bad read zero hold");
  AST_DRIVE_LOW: assert property (masterOut == 1'b0 && deviceOut == 1'b0)
    else $error("driver not open drain");
  AST_SPU_IDLE: assert property (strongPullup |-> masterOeN && deviceOeN)
    else $error("pullup against a driver");

  cover property ($fell(deviceOeN) && st.rstRel);
  cover property ($fell(deviceOeN) && !st.rstRel && !dq);
  cover property ($rose(strongPullup));
endmodule : sws_monitor

// >>> tb/tb.sv
// Self-checking bench: master and device ends joined on one line.
// Assumes a 20 MHz clock; the bench drives both user sides.
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errCount++; $display("Error %0t got %h exp %h", $time, a, e); end end
module tb;
  import sws_pkg::*;
  logic        clock = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, spuEn = 1'b0, crcClear = 1'b0;
  logic        txBit = 1'b0, opDone = 1'b0, lineFed = 1'b0;
  sws_op_t     cmdOp = OP_RESET;
  sws_byte_t   cmdData = 8'h00, mByte, dByte, crc, e;
  logic        cmdReady, done, rxBit, crcOk, rxValid, rxFunction, txTaken, presenceDone, online, resetSeen;
  int          errCount = 0, checked = 0, presCount = 0, rstCount = 0;
  logic [31:0] seed = 32'h0000005d;
  logic [8:0]  rxQ[$];
  logic        txQ[$];

  sws_line_if sws_line_if_i ();
  sws_master sws_master_i (.clock(clock), .reset_n(reset_n), .line(sws_line_if_i.master), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdData(cmdData), .spuEn(spuEn), .crcClear(crcClear), .cmdReady(cmdReady), .done(done),
    .rxBit(rxBit), .rxByte(mByte), .crcOk(crcOk));
  sws_device sws_device_i (.clock(clock), .reset_n(reset_n), .line(sws_line_if_i.device), .txBit(txBit),
    .opDone(opDone), .lineFed(lineFed), .rxByte(dByte), .rxValid(rxValid), .rxFunction(rxFunction),
    .txTaken(txTaken), .resetSeen(resetSeen), .presenceDone(presenceDone), .online(online));
  sws_monitor sws_monitor_i (.clock(clock), .reset_n(reset_n), .masterOut(sws_line_if_i.masterOut),
    .masterOeN(sws_line_if_i.masterOeN), .strongPullup(sws_line_if_i.strongPullup),
    .deviceOut(sws_line_if_i.deviceOut), .deviceOeN(sws_line_if_i.deviceOeN), .dq(sws_line_if_i.dq));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  initial
  begin
    forever #25 clock = ~clock;
  end

  // Collects what the device end hands over and feeds it fresh random read data.
  always @(posedge clock)
  begin
    if (rxValid === 1'b1)
      rxQ.push_back({rxFunction, dByte});
    if (presenceDone === 1'b1)
      presCount++;
    if (resetSeen === 1'b1)
      rstCount++;
    if (txTaken === 1'b1)
    begin
      txQ.push_back(txBit);
      seed = xs(seed);
      txBit <= seed[0];
    end
  end

  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", errCount, checked);
    if (errCount == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic run(input sws_op_t op, input sws_byte_t d);
    int n;
    for (n = 0; n < 100 && cmdReady !== 1'b1; n++)
      @(negedge clock);
    if (n >= 100)
    begin
      errCount++;
      final_report();
    end
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp    <= op;
    cmdData  <= d;
    @(posedge clock);
    cmdValid <= 1'b0;
    for (n = 0; n < 25000 && done !== 1'b1; n++)
      @(negedge clock);
    if (n >= 25000)
    begin
      errCount++;
      final_report();
    end
    @(posedge clock);
  endtask : run

  task automatic wr(input sws_byte_t b, input logic fn);
    run(OP_WRITE_BYTE, b);
    `CHK(rxQ[0], {fn, b})
    rxQ.delete();
  endtask : wr

  task automatic rdBit(input logic x);
    run(OP_READ_BIT, 8'h00);
    `CHK(rxBit, x)
  endtask : rdBit

  initial
  begin
    int n;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rdBit(1'b1);
    `CHK(online, 1'b0)
    run(OP_RESET, 8'h00);
    `CHK(rxBit, 1'b1)
    `CHK(online, 1'b1)
    wr(8'hcc, 1'b0);
    wr(CMD_CONVERT, 1'b1);
    rdBit(1'b0);
    opDone <= 1'b1;
    rdBit(1'b1);
    spuEn <= 1'b1;
    for (n = 0; n < 200 && sws_line_if_i.strongPullup !== 1'b1; n++)
      @(negedge clock);
    `CHK(sws_line_if_i.strongPullup, 1'b1)
    if (n >= 200)
      final_report();
    @(posedge clock);
    spuEn <= 1'b0;
    @(posedge clock);
    run(OP_RESET, 8'h00);
    `CHK(rxBit, 1'b1)
    crcClear <= 1'b1;
    @(posedge clock);
    crcClear <= 1'b0;
    wr(8'hcc, 1'b0);
    wr(CMD_READ_PAD, 1'b1);
    txQ.delete();
    run(OP_READ_BYTE, 8'h00);
    crc = 8'h00;
    for (n = 0; n < 8; n++)
    begin
      e[n] = txQ[n];
      crc = (crc[0] ^ txQ[n]) ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    end
    `CHK(txQ.size(), 8)
    `CHK(mByte, e)
    `CHK(crcOk, crc == 8'h00)
    `CHK(presCount, 2)
    `CHK(rstCount, 2)
    final_report();
  end
endmodule : tb
